// ### common/irq_ctrl_pkg.sv
// constants and types shared by the top-level vectored interrupt controller
package irq_ctrl_pkg;
    // exception table shape
    localparam int NUM_POS = 33;
    localparam int POS_W = 6;
    localparam int PERIPH_BASE = 16;
    localparam int PERIPH_COUNT = 17;
    localparam int PRIO_W = 5;
    localparam int EFF_W = 6;
    localparam int VEC_W = 32;
    // fixed positions
    localparam int POS_SP = 0;
    localparam int POS_RESET = 1;
    localparam int POS_NMI = 2;
    localparam int POS_HARD = 3;
    localparam int POS_MEM = 4;
    localparam int POS_BUS = 5;
    localparam int POS_USAGE = 6;
    localparam int POS_SVC = 11;
    localparam int POS_DBGMON = 12;
    localparam int POS_PEND_SERVICE = 14;
    localparam int POS_SYS_TICK = 15;
    localparam int FIRST_PROG = 4;
    // effective levels: fixed ones below every programmable one
    localparam logic [5:0] LVL_RESET = 6'h00;
    localparam logic [5:0] LVL_NMI = 6'h01;
    localparam logic [5:0] LVL_HARD = 6'h02;
    localparam logic [5:0] LVL_PROG_OFS = 6'h03;
    localparam logic [5:0] LVL_THREAD = 6'h23;
    // implemented peripheral lines: 2-5, 7-10, 12, 14-16
    localparam logic [16:0] PERIPH_MASK = 17'h1D7BC;
    // register byte offsets
    localparam logic [11:0] OFS_ENABLE_SET = 12'h000;
    localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h004;
    localparam logic [11:0] OFS_PEND_SET = 12'h008;
    localparam logic [11:0] OFS_PEND_CLEAR = 12'h00C;
    localparam logic [11:0] OFS_ACTIVE = 12'h010;
    localparam logic [11:0] OFS_SYS_CTRL = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_PRIO_BASE = 12'h100;
    localparam logic [11:0] OFS_VEC_BASE = 12'h200;
    // system control fields
    localparam int CTRL_MEM_EN = 0;
    localparam int CTRL_BUS_EN = 1;
    localparam int CTRL_USAGE_EN = 2;
    localparam int CTRL_DBGMON_EN = 3;
    localparam int CTRL_PEND_SERVICE_SET = 4;
    localparam int CTRL_PEND_SERVICE_CLR = 5;
    // reset values
    localparam logic [16:0] RST_ENABLE = 17'h00000;
    localparam logic [31:0] RST_VECTOR = 32'h00000000;
    localparam logic [4:0] RST_PRIO = 5'h00;

    typedef enum logic [2:0] {
        ST_LOAD_SP = 3'b001,
        ST_LOAD_PC = 3'b010,
        ST_RUN = 3'b100
    } boot_state_type;
endpackage

// ### hw/vectored_irq_ctrl.sv
// top-level vectored interrupt and exception controller with APB registers
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module vectored_irq_ctrl (
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // exception sources
    input wire logic [16:0] periph_irq,
    input wire logic nmi_req,
    input wire logic hard_fault_req,
    input wire logic [2:0] fault_req,
    input wire logic svc_req,
    input wire logic dbg_mon_req,
    input wire logic sys_tick_req,
    // core side
    output logic [16:0] periph_irq_level,
    output logic exc_req,
    output logic [5:0] exc_num,
    output logic [31:0] vector_value,
    output logic sp_load,
    output logic pc_load,
    input wire logic core_ack,
    input wire logic core_return,
    input wire logic [5:0] core_return_num
);
    localparam int N = irq_ctrl_pkg::NUM_POS;

    irq_ctrl_pkg::boot_state_type boot_state;
    logic [31:0] vec_table [N];
    logic [4:0] prio [N];
    logic [16:0] enable;
    logic [16:0] periph_pend;
    logic [15:0] sys_pend;
    logic [N-1:0] active;
    logic [3:0] ctrl_en;
    logic [5:0] eff [N];
    logic [N-1:0] pend_all;
    logic [N-1:0] cand;
    logic [5:0] cur_pri;
    logic [5:0] best_pri;
    logic [5:0] best_num;
    logic take;
    logic wr;
    logic rd_setup;
    logic hit_prio;
    logic hit_vec;
    logic [5:0] word_pos;
    logic mapped;
    logic [31:0] rd_value;
    logic entry;
    logic running;
    logic wr_enable_set;
    logic wr_enable_clear;
    logic wr_pend_set;
    logic wr_pend_clear;
    logic wr_sys_ctrl;

    assign wr = psel && penable && pwrite;
    // one strobe per register: each takes effect only at the access edge of a write
    assign wr_enable_set = wr && (paddr == irq_ctrl_pkg::OFS_ENABLE_SET);
    assign wr_enable_clear = wr && (paddr == irq_ctrl_pkg::OFS_ENABLE_CLEAR);
    assign wr_pend_set = wr && (paddr == irq_ctrl_pkg::OFS_PEND_SET);
    assign wr_pend_clear = wr && (paddr == irq_ctrl_pkg::OFS_PEND_CLEAR);
    assign wr_sys_ctrl = wr && (paddr == irq_ctrl_pkg::OFS_SYS_CTRL);
    assign rd_setup = psel && !penable;
    assign word_pos = paddr[7:2];
    assign hit_prio = (paddr[11:8] == irq_ctrl_pkg::OFS_PRIO_BASE[11:8])
                      && (word_pos < 6'(N)) && (paddr[1:0] == 2'b00);
    assign hit_vec = (paddr[11:8] == irq_ctrl_pkg::OFS_VEC_BASE[11:8])
                     && (word_pos < 6'(N)) && (paddr[1:0] == 2'b00);
    // an ack while no request stands is ignored, so a late ack cannot enter anything
    assign entry = core_ack && exc_req;
    assign running = (boot_state == irq_ctrl_pkg::ST_RUN);
    // single-cycle access: data is prepared in the setup phase
    assign pready = 1'b1;

    // effective level per position and its pending / candidate state
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pos
            if (g == irq_ctrl_pkg::POS_RESET) begin : g_rst
                assign eff[g] = irq_ctrl_pkg::LVL_RESET;
            end else if (g == irq_ctrl_pkg::POS_NMI) begin : g_nmi
                assign eff[g] = irq_ctrl_pkg::LVL_NMI;
            end else if (g == irq_ctrl_pkg::POS_HARD) begin : g_hard
                assign eff[g] = irq_ctrl_pkg::LVL_HARD;
            end else begin : g_prog
                assign eff[g] = {1'b0, prio[g]} + irq_ctrl_pkg::LVL_PROG_OFS;
            end
            if (g >= 18) begin : g_per
                // positions 16 and 17 (masked lines 0 and 1) fall to the tie-off branch below
                assign pend_all[g] = periph_pend[g - irq_ctrl_pkg::PERIPH_BASE];
                assign cand[g] = pend_all[g] && !active[g]
                                 && enable[g - irq_ctrl_pkg::PERIPH_BASE];
            end else if (g >= irq_ctrl_pkg::PERIPH_BASE || g < irq_ctrl_pkg::POS_NMI)
                begin : g_none
                assign pend_all[g] = 1'b0;
                assign cand[g] = 1'b0;
            end else begin : g_sys
                assign pend_all[g] = sys_pend[g];
                assign cand[g] = pend_all[g] && !active[g];
            end
        end
    endgenerate

    // level requests per peripheral line
    always_comb begin
        periph_irq_level = periph_pend & enable & irq_ctrl_pkg::PERIPH_MASK;
    end

    // current execution level: most urgent active exception, else thread; reset level until the boot sequence ends
    always_comb begin
        cur_pri = irq_ctrl_pkg::LVL_THREAD;
        for (int i = 0; i < N; i++) begin
            if (active[i] && eff[i] < cur_pri) begin
                cur_pri = eff[i];
            end
        end
        if (!running) begin
            cur_pri = irq_ctrl_pkg::LVL_RESET;
        end
    end

    // most urgent candidate; ascending scan with strict compare keeps the lowest position
    always_comb begin
        best_pri = irq_ctrl_pkg::LVL_THREAD;
        best_num = 6'h00;
        for (int i = 0; i < N; i++) begin
            if (cand[i] && eff[i] < best_pri) begin
                best_pri = eff[i];
                best_num = 6'(i);
            end
        end
        // strict compare: equal level never preempts, so NMI stays in service
        take = running && (best_pri < cur_pri);
    end

    // boot sequence: stack pointer, then reset vector, then thread level
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            boot_state <= irq_ctrl_pkg::ST_LOAD_SP;
        end else begin
            unique case (boot_state)
                irq_ctrl_pkg::ST_LOAD_SP: boot_state <= irq_ctrl_pkg::ST_LOAD_PC;
                irq_ctrl_pkg::ST_LOAD_PC: boot_state <= irq_ctrl_pkg::ST_RUN;
                irq_ctrl_pkg::ST_RUN: boot_state <= irq_ctrl_pkg::ST_RUN;
                default: boot_state <= irq_ctrl_pkg::ST_LOAD_SP;
            endcase
        end
    end

    // core-facing outputs except periph_irq_level, all from flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sp_load <= 1'b0;
            pc_load <= 1'b0;
            exc_req <= 1'b0;
            exc_num <= 6'h00;
            vector_value <= irq_ctrl_pkg::RST_VECTOR;
        end else begin
            sp_load <= (boot_state == irq_ctrl_pkg::ST_LOAD_SP);
            pc_load <= (boot_state == irq_ctrl_pkg::ST_LOAD_PC);
            // suppress the request in the cycle after an entry so a stale pick is not shown
            exc_req <= take && !entry;
            if (boot_state == irq_ctrl_pkg::ST_LOAD_SP) begin
                vector_value <= vec_table[irq_ctrl_pkg::POS_SP];
                exc_num <= 6'(irq_ctrl_pkg::POS_SP);
            end else if (boot_state == irq_ctrl_pkg::ST_LOAD_PC) begin
                vector_value <= vec_table[irq_ctrl_pkg::POS_RESET];
                exc_num <= 6'(irq_ctrl_pkg::POS_RESET);
            end else if (take && !entry) begin
                vector_value <= vec_table[best_num];
                exc_num <= best_num;
            end
        end
    end

    // vector table and priority storage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < N; i++) begin
                vec_table[i] <= irq_ctrl_pkg::RST_VECTOR;
                prio[i] <= irq_ctrl_pkg::RST_PRIO;
            end
        end else if (wr) begin
            if (hit_vec) begin
                vec_table[word_pos] <= pwdata;
            end
            // fixed levels are not programmable
            if (hit_prio && word_pos >= 6'(irq_ctrl_pkg::FIRST_PROG)) begin
                prio[word_pos] <= pwdata[4:0];
            end
        end
    end

    // enable mask: write-one set and clear, zeros ignored
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enable <= irq_ctrl_pkg::RST_ENABLE;
        end else if (wr_enable_set) begin
            enable <= enable | (pwdata[16:0] & irq_ctrl_pkg::PERIPH_MASK);
        end else if (wr_enable_clear) begin
            enable <= enable & ~pwdata[16:0];
        end
    end

    // peripheral pend latches; a set in the same cycle as a clear wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            periph_pend <= 17'h00000;
        end else begin
            for (int b = 0; b < irq_ctrl_pkg::PERIPH_COUNT; b++) begin
                if (irq_ctrl_pkg::PERIPH_MASK[b]) begin
                    if (periph_irq[b]
                        || (wr_pend_set && pwdata[b])) begin
                        periph_pend[b] <= 1'b1;
                    end else if ((wr_pend_clear && pwdata[b])
                        || (entry && exc_num == 6'(b + irq_ctrl_pkg::PERIPH_BASE))) begin
                        periph_pend[b] <= 1'b0;
                    end
                end else begin
                    periph_pend[b] <= 1'b0;
                end
            end
        end
    end

    // fault handler enables and debug monitor enable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_en <= 4'h0;
        end else if (wr_sys_ctrl) begin
            ctrl_en <= pwdata[3:0];
        end
    end

    // system exception pend bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sys_pend <= 16'h0000;
        end else begin
            for (int p = irq_ctrl_pkg::POS_NMI; p < irq_ctrl_pkg::PERIPH_BASE; p++) begin
                if (entry && exc_num == 6'(p)) begin
                    sys_pend[p] <= 1'b0;
                end
            end
            if (nmi_req) begin
                sys_pend[irq_ctrl_pkg::POS_NMI] <= 1'b1;
            end
            if (hard_fault_req) begin
                sys_pend[irq_ctrl_pkg::POS_HARD] <= 1'b1;
            end
            for (int f = 0; f < 3; f++) begin
                if (fault_req[f]) begin
                    // a fault that cannot run now goes to the hard fault handler
                    if (ctrl_en[f] && eff[irq_ctrl_pkg::POS_MEM + f] < cur_pri) begin
                        sys_pend[irq_ctrl_pkg::POS_MEM + f] <= 1'b1;
                    end else begin
                        sys_pend[irq_ctrl_pkg::POS_HARD] <= 1'b1;
                    end
                end
            end
            if (svc_req) begin
                sys_pend[irq_ctrl_pkg::POS_SVC] <= 1'b1;
            end
            // dropped, not held, when disabled or not more urgent than the current level
            if (dbg_mon_req && ctrl_en[irq_ctrl_pkg::CTRL_DBGMON_EN]
                && eff[irq_ctrl_pkg::POS_DBGMON] < cur_pri) begin
                sys_pend[irq_ctrl_pkg::POS_DBGMON] <= 1'b1;
            end
            // only software reaches this bit; no hardware input sets it
            if (wr_sys_ctrl) begin
                if (pwdata[irq_ctrl_pkg::CTRL_PEND_SERVICE_SET]) begin
                    sys_pend[irq_ctrl_pkg::POS_PEND_SERVICE] <= 1'b1;
                end else if (pwdata[irq_ctrl_pkg::CTRL_PEND_SERVICE_CLR]) begin
                    sys_pend[irq_ctrl_pkg::POS_PEND_SERVICE] <= 1'b0;
                end
            end
            if (sys_tick_req) begin
                sys_pend[irq_ctrl_pkg::POS_SYS_TICK] <= 1'b1;
            end
            sys_pend[1:0] <= 2'b00;
        end
    end

    // in-service tracking, driven only by the core handshake
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active <= '0;
        end else begin
            // an entry beats a return that names the same position
            for (int i = 0; i < N; i++) begin
                if (entry && exc_num == 6'(i)) begin
                    active[i] <= 1'b1;
                end else if (core_return && core_return_num == 6'(i)) begin
                    active[i] <= 1'b0;
                end
            end
        end
    end

    // read decode
    always_comb begin
        rd_value = 32'h00000000;
        mapped = 1'b1;
        if (hit_vec) begin
            rd_value = vec_table[word_pos];
        end else if (hit_prio) begin
            rd_value = {27'h0000000, prio[word_pos]};
        end else begin
            unique case (paddr)
                irq_ctrl_pkg::OFS_ENABLE_SET, irq_ctrl_pkg::OFS_ENABLE_CLEAR:
                    rd_value = {15'h0000, enable};
                irq_ctrl_pkg::OFS_PEND_SET, irq_ctrl_pkg::OFS_PEND_CLEAR:
                    rd_value = {15'h0000, periph_pend};
                irq_ctrl_pkg::OFS_ACTIVE:
                    rd_value = {15'h0000, active[N-1:irq_ctrl_pkg::PERIPH_BASE]};
                irq_ctrl_pkg::OFS_SYS_CTRL:
                    rd_value = {27'h0000000, sys_pend[irq_ctrl_pkg::POS_PEND_SERVICE], ctrl_en};
                irq_ctrl_pkg::OFS_STATUS:
                    rd_value = {8'h00, 2'b00, cur_pri, 2'b00, best_num, 2'b00, exc_num};
                default: mapped = 1'b0;
            endcase
        end
    end

    // read data captured in the setup phase; writes to read-only words are ignored
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_value;
            pslverr <= !mapped;
        end
    end
endmodule // vectored_irq_ctrl

// ### tb/irq_ctrl_monitor.sv
// port-level assertions for the vectored interrupt controller
`timescale 1ns/1ps
module irq_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic nmi_req,
    input wire logic [2:0] fault_req,
    input wire logic [16:0] periph_irq_level,
    input wire logic exc_req,
    input wire logic [5:0] exc_num,
    input wire logic [31:0] vector_value,
    input wire logic sp_load,
    input wire logic pc_load,
    input wire logic core_ack
);
    default clocking mon_cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_boot_order: assert property (
        $fell(reset) |=> sp_load && !pc_load ##1 pc_load && !sp_load)
        else $error("boot loads out of order");
    a_stack_entry: assert property (
        sp_load |-> exc_num == 6'h00 && vector_value == irq_ctrl_pkg::RST_VECTOR)
        else $error("stack load not from entry zero");
    a_reset_entry: assert property (
        pc_load |-> exc_num == 6'h01)
        else $error("reset vector load not from entry one");
    a_level_mask: assert property (
        (periph_irq_level & ~irq_ctrl_pkg::PERIPH_MASK) == 17'h00000)
        else $error("request on an unimplemented peripheral slot");
    a_ack_drop: assert property (
        core_ack && exc_req |=> !exc_req)
        else $error("request held after it was taken");
    a_req_legal: assert property (
        exc_req |-> exc_num <= 6'h20 && !(exc_num inside {[6'h00:6'h01], [6'h07:6'h0A],
            6'h0D, [6'h10:6'h11], 6'h16, 6'h1B, 6'h1D}))
        else $error("request names a reserved position");
    a_nmi_first: assert property (
        $rose(nmi_req) |-> ##[1:4] exc_req && exc_num == 6'h02)
        else $error("non-maskable request not presented");
    a_fault_escalate: assert property (
        $rose(fault_req[0]) |-> ##[1:6] exc_req && exc_num inside {6'h02, 6'h03})
        else $error("disabled fault did not escalate");
endmodule // irq_ctrl_monitor

bind vectored_irq_ctrl irq_ctrl_monitor monitor (.clk_sys(clk_sys), .reset(reset),
    .nmi_req(nmi_req), .fault_req(fault_req), .periph_irq_level(periph_irq_level),
    .exc_req(exc_req), .exc_num(exc_num), .vector_value(vector_value),
    .sp_load(sp_load), .pc_load(pc_load), .core_ack(core_ack));

// ### tb/core_model.sv
// processor core model: takes one exception at a time, returns after a hold
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic exc_req,
    input wire logic [5:0] exc_num,
    input wire logic [31:0] vector_value,
    input wire logic [3:0] ack_wait,
    input wire logic [7:0] hold_cycles,
    output logic core_ack,
    output logic core_return,
    output logic [5:0] core_return_num,
    output logic [7:0] n_taken,
    output logic [5:0] last_num,
    output logic [31:0] last_vec
);
    logic busy;
    logic [7:0] cnt;
    // no nesting: a slow core that finishes each handler before the next
    always_ff @(posedge clk_sys) begin
        core_ack <= 1'b0;
        core_return <= 1'b0;
        if (reset) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            n_taken <= 8'h00;
            last_num <= 6'h00;
            last_vec <= 32'h00000000;
            core_return_num <= 6'h00;
        end else if (!busy) begin
            if (exc_req && cnt >= {4'h0, ack_wait}) begin
                core_ack <= 1'b1;
                busy <= 1'b1;
                cnt <= 8'h00;
            end else begin
                cnt <= exc_req ? cnt + 8'h01 : 8'h00;
            end
        end else if (cnt >= hold_cycles) begin
            core_return <= 1'b1;
            core_return_num <= last_num;
            busy <= 1'b0;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
        // what is taken is what stands at the edge that samples the ack
        if (!reset && core_ack && exc_req) begin
            last_num <= exc_num;
            last_vec <= vector_value;
            n_taken <= n_taken + 8'h01;
        end
    end
endmodule // core_model

// ### tb/vectored_irq_ctrl_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vectored_irq_ctrl_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, r, vector_value, last_vec;
    logic [16:0] periph_irq = 17'h00000, periph_irq_level;
    logic nmi_req = 1'b0, svc_req = 1'b0, dbg_mon_req = 1'b0, sys_tick_req = 1'b0;
    logic hard_fault_req = 1'b0;
    logic [2:0] fault_req = 3'h0;
    logic exc_req, sp_load, pc_load, core_ack, core_return;
    logic [5:0] exc_num, core_return_num, last_num;
    logic [3:0] ack_wait = 4'h0;
    logic [7:0] hold_cycles = 8'h14, n_taken, seen = 8'h00;
    int n_errors = 0, tests_run = 0;
    always #12.5 clk_sys = ~clk_sys;
    vectored_irq_ctrl dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_irq(periph_irq), .nmi_req(nmi_req),
        .hard_fault_req(hard_fault_req), .fault_req(fault_req), .svc_req(svc_req),
        .dbg_mon_req(dbg_mon_req), .sys_tick_req(sys_tick_req),
        .periph_irq_level(periph_irq_level), .exc_req(exc_req), .exc_num(exc_num),
        .vector_value(vector_value), .sp_load(sp_load), .pc_load(pc_load),
        .core_ack(core_ack), .core_return(core_return), .core_return_num(core_return_num));
    core_model core (.clk_sys(clk_sys), .reset(reset), .exc_req(exc_req), .exc_num(exc_num),
        .vector_value(vector_value), .ack_wait(ack_wait), .hold_cycles(hold_cycles),
        .core_ack(core_ack), .core_return(core_return), .core_return_num(core_return_num),
        .n_taken(n_taken), .last_num(last_num), .last_vec(last_vec));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // one apb transfer; read data lands in r
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // vector of position p was programmed as 16 * p
    task automatic take(input logic [5:0] num);
        for (int i = 0; i < 80 && n_taken === seen; i++) @(posedge clk_sys);
        chk("take count", 32'(seen) + 32'h1, 32'(n_taken));
        seen = n_taken;
        chk("taken number", 32'(num), 32'(last_num));
        chk("taken vector", 32'(num) * 32'h10, last_vec);
    endtask
    task automatic end_test(input string n);
        repeat (40) @(posedge clk_sys);
        $display("test %s finished", n);
    endtask
    task automatic pulse_idle_check(input string n);
        repeat (30) @(posedge clk_sys);
        chk(n, 32'(seen), 32'(n_taken));
    endtask
    initial begin
        repeat (10000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("stack load", 32'h1, 32'(sp_load));
        chk("stack entry", 32'h0, vector_value);
        @(negedge clk_sys);
        chk("reset vector load", 32'h1, 32'(pc_load));
        @(posedge clk_sys);
        for (int p = 2; p < 33; p++) apb(1'b1, 12'h200 + 12'(4 * p), 32'(p) * 32'h10);
        end_test("boot");
        apb(1'b1, 12'h008, 32'h00000004);
        pulse_idle_check("take while disabled");
        chk("gated level", 32'h0, 32'(periph_irq_level));
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b1, 12'h00C, 32'h00000000);
        apb(1'b0, 12'h000, 32'h00000000);
        chk("enable after zero write", 32'h0, r);
        apb(1'b0, 12'h008, 32'h00000000);
        chk("pend after zero write", 32'h4, r);
        apb(1'b0, 12'h018, 32'h00000000);
        chk("idle status", 32'h00230001, r);
        apb(1'b1, 12'h000, 32'h00005004);
        take(6'h12);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        apb(1'b0, 12'h010, 32'h00000000);
        chk("active in service", 32'h4, r);
        repeat (25) @(posedge clk_sys);
        apb(1'b0, 12'h010, 32'h00000000);
        chk("active after return", 32'h0, r);
        end_test("mask and pend");
        apb(1'b1, 12'h008, 32'h00005000);
        take(6'h1C);
        take(6'h1E);
        apb(1'b1, 12'h178, 32'h00000001);
        apb(1'b1, 12'h170, 32'h00000002);
        apb(1'b1, 12'h008, 32'h00005000);
        take(6'h1E);
        take(6'h1C);
        end_test("priority");
        apb(1'b1, 12'h004, 32'h00004000);
        apb(1'b0, 12'h000, 32'h00000000);
        chk("enable after clear", 32'h1004, r);
        apb(1'b1, 12'h008, 32'h00004000);
        apb(1'b0, 12'h00C, 32'h00000000);
        chk("pend while disabled", 32'h4000, r);
        apb(1'b1, 12'h00C, 32'h00004000);
        apb(1'b0, 12'h008, 32'h00000000);
        chk("pend after clear", 32'h0, r);
        apb(1'b1, 12'h000, 32'h00000008);
        periph_irq <= 17'h00008;
        take(6'h13);
        chk("line level", 32'h8, 32'(periph_irq_level));
        periph_irq <= 17'h00000;
        apb(1'b1, 12'h00C, 32'h00000008);
        apb(1'b1, 12'h300, 32'h00000001);
        chk("unmapped error", 32'h1, 32'(pslverr));
        end_test("clear and lines");
        ack_wait <= 4'h8;
        nmi_req <= 1'b1;
        fault_req <= 3'b001;
        @(posedge clk_sys);
        nmi_req <= 1'b0;
        fault_req <= 3'b000;
        apb(1'b1, 12'h008, 32'h00001000);
        take(6'h02);
        take(6'h03);
        take(6'h1C);
        apb(1'b1, 12'h014, 32'h00000010);
        take(6'h0E);
        // let the pendable handler return so only the disabled enable can drop the pulse
        repeat (25) @(posedge clk_sys);
        dbg_mon_req <= 1'b1;
        @(posedge clk_sys);
        dbg_mon_req <= 1'b0;
        pulse_idle_check("monitor while disabled");
        apb(1'b1, 12'h014, 32'h00000008);
        dbg_mon_req <= 1'b1;
        @(posedge clk_sys);
        dbg_mon_req <= 1'b0;
        take(6'h0C);
        sys_tick_req <= 1'b1;
        svc_req <= 1'b1;
        @(posedge clk_sys);
        sys_tick_req <= 1'b0;
        svc_req <= 1'b0;
        take(6'h0B);
        take(6'h0F);
        repeat (25) @(posedge clk_sys);
        apb(1'b1, 12'h014, 32'h00000001);
        hard_fault_req <= 1'b1;
        fault_req <= 3'b001;
        @(posedge clk_sys);
        hard_fault_req <= 1'b0;
        fault_req <= 3'b000;
        take(6'h03);
        take(6'h04);
        end_test("fixed and system");
        report_and_stop();
    end
endmodule // vectored_irq_ctrl_tb
